// ---- jvpe_engine.sv ----
// Boundary-scan vector engine: drives TCK/TDI/TMS, samples TDO, times idle runs
// and controls the auxiliary pin. Assumes a Wishbone master on the same clock.
//
// Overview of operation
// - Drive TDI, TCK, TMS; receive TDO separately
// - Aux pin mode during and after execution
// - Default frequency until a frequency command
// - Extended format disregards frequency commands, keeps current frequency
// - Test clock never above 15 MHz
// - Ignore setting disregards all frequency commands
// - Fast option samples TDO on falling edge
// - Time-only idle lasts at least that time
// - Idle clocking: none, slow, or default
// - No-clock idle timing is nearly exact
// - Idle waits lengthened by configurable percentage
// - Count-only idle: clocks or 1 MHz time
// - Count plus time runs at current clock
// - Maximum-time deadline is ignored
// - FPGA profile is the reset profile
// - CPLD profile loadable
// - Microcontroller profile loadable
// - Divider yields 12.5, 8.33, 6.25, 5 MHz and lower
// - Test reset and system clock never together
`timescale 1ns/1ps
module jvpe_engine (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire jvpe_pkg::jvpe_wb_t wb_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   tck_o,
  output logic                   tdi_o,
  output logic                   tms_o,
  input  wire logic              tdo_i,
  output logic                   aux_o,
  output logic                   aux_oe_o
);
  // ==========================================================
  // State
  jvpe_pkg::jvpe_state_t s, n;
  logic [15:0] thr;
  logic [31:0] wv;
  logic [1:0]  op, mode;
  logic [23:0] arg;
  logic        acc_req, lvl, tick, wr_cmd;

  if (jvpe_pkg::MIN_HALF < 1 || jvpe_pkg::SLOW_HALF < jvpe_pkg::MIN_HALF) begin : g_chk
    $error("Clock rates cannot serve the test clock");
  end

  function automatic logic [31:0] jvpe_merge(input logic [31:0] o, input logic [31:0] d,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction : jvpe_merge

  assign acc_req = wb_i.cyc && wb_i.stb && !s.ack;
  assign wr_cmd  = acc_req && wb_i.we && wb_i.adr == jvpe_pkg::A_CMD && s.fsm == jvpe_pkg::ST_IDLE;

  always_comb begin
    n     = s;
    n.ack = 1'b0;
    thr   = 16'(jvpe_pkg::US_CYC * (jvpe_pkg::PCT_BASE + int'(s.pct)));
    op    = wb_i.dat[1:0];
    arg   = wb_i.dat[31:8];
    wv    = '0;
    tick  = 1'b0;
    n.tdo_s1 = tdo_i;
    n.tdo_s2 = s.tdo_s1;
    // ==========================================================
    // Wishbone slave: one-cycle answer, unmapped reads return zero
    if (acc_req) begin
      n.ack  = 1'b1;
      n.rdat = '0;
      case (wb_i.adr)
        jvpe_pkg::A_CTRL: n.rdat = 32'(s.ctrl);
        jvpe_pkg::A_DDIV: n.rdat = 32'(s.defdiv);
        jvpe_pkg::A_PCT:  n.rdat = 32'(s.pct);
        jvpe_pkg::A_DATA: n.rdat = s.cap;
        jvpe_pkg::A_TMS:  n.rdat = s.tmsr;
        jvpe_pkg::A_TIME: n.rdat = 32'(s.timeus);
        jvpe_pkg::A_STAT: n.rdat = {s.curdiv, 12'h000, s.tdo_s2, s.aux_oe, s.tck, s.fsm != jvpe_pkg::ST_IDLE};
        default:          n.rdat = '0;
      endcase
      if (wb_i.we) begin
        case (wb_i.adr)
          jvpe_pkg::A_CTRL: begin
            wv     = jvpe_merge(32'(s.ctrl), wb_i.dat, wb_i.sel);
            n.ctrl = wv[12:0];
          end
          jvpe_pkg::A_DDIV: begin
            wv = jvpe_merge(32'(s.defdiv), wb_i.dat, wb_i.sel);
            n.defdiv = (wv[15:0] < jvpe_pkg::DIV_FPGA) ? jvpe_pkg::DIV_FPGA : wv[15:0];
          end
          jvpe_pkg::A_PCT: if (wb_i.sel[0]) n.pct = wb_i.dat[7:0];
          jvpe_pkg::A_DATA: if (s.fsm == jvpe_pkg::ST_IDLE) n.data = jvpe_merge(s.data, wb_i.dat, wb_i.sel);
          jvpe_pkg::A_TMS: if (s.fsm == jvpe_pkg::ST_IDLE) n.tmsr = jvpe_merge(s.tmsr, wb_i.dat, wb_i.sel);
          jvpe_pkg::A_TIME: begin
            wv       = jvpe_merge(32'(s.timeus), wb_i.dat, wb_i.sel);
            n.timeus = wv[23:0];
          end
          jvpe_pkg::A_PROF: begin
            case (wb_i.dat[1:0])
              jvpe_pkg::PROF_CPLD: begin
                n.ctrl   = jvpe_pkg::CTRL_CPLD;
                n.defdiv = jvpe_pkg::DIV_CPLD;
                n.pct    = jvpe_pkg::PCT_CPLD;
              end
              jvpe_pkg::PROF_MCU: begin
                n.ctrl   = jvpe_pkg::CTRL_MCU;
                n.defdiv = jvpe_pkg::DIV_MCU;
                n.pct    = jvpe_pkg::PCT_MCU;
              end
              default: begin
                n.ctrl   = jvpe_pkg::CTRL_FPGA;
                n.defdiv = jvpe_pkg::DIV_FPGA;
                n.pct    = jvpe_pkg::PCT_FPGA;
              end
            endcase
            n.curdiv = n.defdiv;
          end
          default: ;
        endcase
      end
    end
    // ==========================================================
    // Command start; commands written while busy are dropped
    if (wr_cmd) begin
      case (op)
        jvpe_pkg::OP_SHIFT: if (arg != '0) begin
          n.cnt  = (arg > 24'(jvpe_pkg::SHIFT_MAX)) ? 24'(jvpe_pkg::SHIFT_MAX) : arg;
          n.fsm  = jvpe_pkg::ST_SHIFT;
          n.half = s.curdiv;
          n.tdi  = s.data[0];
          n.tms  = s.tmsr[0];
        end
        jvpe_pkg::OP_RUN: begin
          n.fsm     = jvpe_pkg::ST_RUN;
          n.acc     = '0;
          n.half    = s.curdiv;
          n.cnt     = arg;
          n.us_left = s.timeus;
          n.time_v  = wb_i.dat[3];
          n.cnt_v   = wb_i.dat[2];
          n.rdiv    = s.curdiv;
          n.clk_on  = 1'b1;
          if (wb_i.dat[2] && !wb_i.dat[3] && s.ctrl.cnt_time) begin
            n.cnt_v   = 1'b0;
            n.time_v  = 1'b1;
            n.us_left = arg;
          end
          if (!n.cnt_v) begin
            n.clk_on = s.ctrl.idle != jvpe_pkg::IDLE_NONE;
            n.rdiv   = (s.ctrl.idle == jvpe_pkg::IDLE_SLOW) ? 16'(jvpe_pkg::SLOW_HALF) : s.defdiv;
            n.half   = n.rdiv;
          end
        end
        jvpe_pkg::OP_FREQ: if (!s.ctrl.ign_freq && !s.ctrl.ext_fmt) begin
          if (wb_i.dat[2]) n.curdiv = s.defdiv;
          else n.curdiv = (arg[15:0] < jvpe_pkg::DIV_FPGA) ? jvpe_pkg::DIV_FPGA : arg[15:0];
        end
        default: n.trst_lvl = wb_i.dat[2];
      endcase
    end
    // ==========================================================
    // Engine
    case (s.fsm)
      jvpe_pkg::ST_SHIFT: begin
        if (s.half > 16'h0001) begin
          n.half = s.half - 16'h0001;
        end else begin
          n.half = s.curdiv;
          n.tck  = !s.tck;
          if (!s.tck) begin
            if (!s.ctrl.fast) n.cap = {s.tdo_s2, s.cap[31:1]};
          end else begin
            if (s.ctrl.fast) n.cap = {s.tdo_s2, s.cap[31:1]};
            n.cnt = s.cnt - 24'h000001;
            if (s.cnt == 24'h000001) begin
              n.fsm = jvpe_pkg::ST_IDLE;
            end else begin
              n.data = {1'b0, s.data[31:1]};
              n.tmsr = {1'b0, s.tmsr[31:1]};
              n.tdi  = s.data[1];
              n.tms  = s.tmsr[1];
            end
          end
        end
      end
      jvpe_pkg::ST_RUN: begin
        // Scaled microsecond tick stretched by the added percentage
        if (s.acc + 16'(jvpe_pkg::PCT_BASE) >= thr) begin
          n.acc = s.acc + 16'(jvpe_pkg::PCT_BASE) - thr;
          tick  = 1'b1;
        end else begin
          n.acc = s.acc + 16'(jvpe_pkg::PCT_BASE);
        end
        if (tick && s.us_left != '0) n.us_left = s.us_left - 24'h000001;
        if (s.clk_on) begin
          if (s.half > 16'h0001) begin
            n.half = s.half - 16'h0001;
          end else begin
            n.half = s.rdiv;
            n.tck  = !s.tck;
            if (s.tck && s.cnt_v && s.cnt != '0) n.cnt = s.cnt - 24'h000001;
          end
        end
        // Finish on a low clock once both count and time are met; no deadline is kept
        if ((!s.cnt_v || s.cnt == '0) && (!s.time_v || s.us_left == '0) && !s.tck) begin
          n.fsm = jvpe_pkg::ST_IDLE;
          n.tck = 1'b0;
        end
      end
      default: n.tck = 1'b0;
    endcase
    // ==========================================================
    // Auxiliary pin: one function per phase, so reset and clock never meet
    mode = s.ctrl.running ? s.ctrl.aux_run : s.ctrl.aux_aft;
    lvl  = s.ctrl.running ? s.ctrl.run_lvl : s.ctrl.aft_lvl;
    case (mode)
      jvpe_pkg::AUX_TRI: begin
        n.aux_oe = 1'b0;
        n.aux    = 1'b0;
      end
      jvpe_pkg::AUX_TRST: begin
        n.aux_oe = 1'b1;
        n.aux    = n.trst_lvl;
      end
      jvpe_pkg::AUX_SCK: begin
        n.aux_oe = 1'b1;
        n.aux    = (n.fsm == jvpe_pkg::ST_RUN) && n.tck;
      end
      default: begin
        n.aux_oe = 1'b1;
        n.aux    = lvl;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s        <= '0;
      s.ctrl   <= jvpe_pkg::CTRL_FPGA;
      s.defdiv <= jvpe_pkg::DIV_FPGA;
      s.curdiv <= jvpe_pkg::DIV_FPGA;
      s.pct    <= jvpe_pkg::PCT_FPGA;
    end else begin
      s <= n;
    end
  end

  assign wb_dat_o = s.rdat;
  assign wb_ack_o = s.ack;
  assign tck_o    = s.tck;
  assign tdi_o    = s.tdi;
  assign tms_o    = s.tms;
  assign aux_o    = s.aux;
  assign aux_oe_o = s.aux_oe;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_freq_wr;
    wr_cmd && op == jvpe_pkg::OP_FREQ && !s.ctrl.ign_freq && !s.ctrl.ext_fmt;
  endsequence
  sequence s_tck_edge;
    $changed(s.tck) ##1 $stable(s.tck);
  endsequence

  property p_tck_half;
    $changed(s.tck) |-> s_tck_edge;
  endproperty
  a_tck_half: assert property (p_tck_half) else $error("Test clock half period too short");
  property p_pin_low;
    ($changed(s.tdi) || $changed(s.tms)) |-> !s.tck;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("TDI or TMS changed with TCK high");
  property p_freq_ign;
    (wr_cmd && op == jvpe_pkg::OP_FREQ && (s.ctrl.ign_freq || s.ctrl.ext_fmt)) |=> $stable(s.curdiv);
  endproperty
  a_freq_ign: assert property (p_freq_ign) else $error("Frequency command not ignored");
  property p_freq_def;
    s_freq_wr ##0 wb_i.dat[2] |=> s.curdiv == s.defdiv;
  endproperty
  a_freq_def: assert property (p_freq_def) else $error("Default frequency not restored");
  property p_no_clk;
    (s.fsm == jvpe_pkg::ST_RUN && !s.clk_on) |-> !s.tck;
  endproperty
  a_no_clk: assert property (p_no_clk) else $error("Clock pulse in no-clock idle run");
  property p_min_time;
    (s.fsm == jvpe_pkg::ST_RUN && n.fsm == jvpe_pkg::ST_IDLE && s.time_v) |-> s.us_left == '0;
  endproperty
  a_min_time: assert property (p_min_time) else $error("Idle run ended before its time");
  property p_aux_tri;
    (!s.ctrl.running && s.ctrl.aux_aft == jvpe_pkg::AUX_TRI) |=> !s.aux_oe;
  endproperty
  a_aux_tri: assert property (p_aux_tri) else $error("Aux pin driven while set to tristate");
  property p_fast;
    ($changed(s.cap) && $past(s.ctrl.fast)) |-> $fell(s.tck);
  endproperty
  a_fast: assert property (p_fast) else $error("Fast sampling not on falling edge");
endmodule : jvpe_engine

// ---- jvpe_engine_tb.sv ----
// Self-checking bench for the boundary-scan vector engine.
// Assumes the engine package and the target model are compiled first.
`timescale 1ns/1ps
module jvpe_engine_tb;
  localparam logic [31:0] PAT = 32'h5ac396e1;
  logic clk_i, rst_i, wb_ack_o, tck_o, tdi_o, tms_o, tdo_i, aux_o, aux_oe_o;
  logic tck_q, aux_q, tdi_q, tms_q;
  logic [31:0] wb_dat_o, q, cap_tdi, cap_tms;
  jvpe_pkg::jvpe_wb_t wb;
  int mismatches = 0, n_checks = 0, cyc_cnt = 0, rises = 0, aux_rises = 0, skew = 0, cyc, tk;

  jvpe_engine DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tck_o(tck_o), .tdi_o(tdi_o), .tms_o(tms_o), .tdo_i(tdo_i), .aux_o(aux_o), .aux_oe_o(aux_oe_o));
  jvpe_tap_model #(.PATTERN(PAT)) tap (.tck_i(tck_o), .tdi_i(tdi_o), .tms_i(tms_o), .tdo_o(tdo_i),
    .tdi_cap_o(cap_tdi), .tms_cap_o(cap_tms));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // ==========================================================
  // Edge counters and data-setup watch
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    tck_q <= tck_o;
    aux_q <= aux_o;
    tdi_q <= tdi_o;
    tms_q <= tms_o;
    if (tck_o === 1'b1 && tck_q === 1'b0) rises <= rises + 1;
    if (aux_o === 1'b1 && aux_q === 1'b0) aux_rises <= aux_rises + 1;
    if (!rst_i && tck_o === 1'b1 && (tdi_o !== tdi_q || tms_o !== tms_q)) skew <= skew + 1;
  end
  // ==========================================================
  // Shared tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb <= '0;
    if (n >= 50) begin
      mismatches++;
      summarize();
    end
  endtask : xfer

  function automatic logic [31:0] cmd(input logic [1:0] op, input logic f1, f2, input logic [23:0] arg);
    return {arg, 4'h0, f2, f1, op};
  endfunction : cmd

  // Issues a command and polls until idle, measuring cycles and test clock rises
  task automatic run(input logic [31:0] c);
    int n, t0, r0;
    xfer(jvpe_pkg::A_CMD, 1'b1, c);
    t0 = cyc_cnt;
    r0 = rises;
    n = 0;
    do begin
      xfer(jvpe_pkg::A_STAT, 1'b0, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 3000);
    cyc = cyc_cnt - t0;
    tk = rises - r0;
    if (n >= 3000) begin
      mismatches++;
      summarize();
    end
  endtask : run

  task automatic div_is(input logic [15:0] e);
    xfer(jvpe_pkg::A_STAT, 1'b0, 32'h0);
    chk("divider", {16'h0, q[31:16]}, {16'h0, e});
  endtask : div_is

  task automatic pins(input logic oe, input logic lvl);
    repeat (3) @(posedge clk_i);
    chk("aux_oe_o", {31'h0, aux_oe_o}, {31'h0, oe});
    chk("aux_o", {31'h0, aux_o}, {31'h0, lvl});
  endtask : pins
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    pins(1'b0, 1'b0);
    xfer(jvpe_pkg::A_CTRL, 1'b0, 32'h0);
    chk("ctrl", q, 32'(jvpe_pkg::CTRL_FPGA));
    xfer(jvpe_pkg::A_DDIV, 1'b0, 32'h0);
    chk("ddiv", q, 32'(jvpe_pkg::DIV_FPGA));
    xfer(jvpe_pkg::A_STAT, 1'b0, 32'h0);
    chk("stat", q & 32'hffff0007, {jvpe_pkg::DIV_FPGA, 16'h0});
    xfer(8'h24, 1'b1, 32'hffffffff);
    xfer(8'h24, 1'b0, 32'h0);
    chk("unmapped", q, 32'h0);
    xfer(jvpe_pkg::A_CTRL, 1'b0, 32'h0);
    chk("ctrl kept", q, 32'(jvpe_pkg::CTRL_FPGA));
  endtask : t_reset

  task automatic t_freq();
    run(cmd(jvpe_pkg::OP_FREQ, 1'b0, 1'b0, 24'h5));
    div_is(16'h2);
    xfer(jvpe_pkg::A_CTRL, 1'b1, 32'h32);
    run(cmd(jvpe_pkg::OP_FREQ, 1'b0, 1'b0, 24'h9));
    div_is(16'h2);
    xfer(jvpe_pkg::A_CTRL, 1'b1, 32'h30);
    run(cmd(jvpe_pkg::OP_FREQ, 1'b0, 1'b0, 24'h1));
    div_is(16'h2);
    run(cmd(jvpe_pkg::OP_FREQ, 1'b0, 1'b0, 24'h7));
    div_is(16'h7);
    xfer(jvpe_pkg::A_DDIV, 1'b1, 32'h5);
    run(cmd(jvpe_pkg::OP_FREQ, 1'b1, 1'b0, 24'h0));
    div_is(16'h5);
  endtask : t_freq

  task automatic t_shift(input logic [31:0] ctrl, input logic [7:0] d, m, input int k);
    xfer(jvpe_pkg::A_CTRL, 1'b1, ctrl);
    xfer(jvpe_pkg::A_DATA, 1'b1, {24'h0, d});
    xfer(jvpe_pkg::A_TMS, 1'b1, {24'h0, m});
    run(cmd(jvpe_pkg::OP_SHIFT, 1'b0, 1'b0, 24'd8));
    chk("shift clocks", 32'(tk), 32'd8);
    chk("target tdi", {24'h0, cap_tdi[31:24]}, {24'h0, d});
    chk("target tms", {24'h0, cap_tms[31:24]}, {24'h0, m});
    xfer(jvpe_pkg::A_DATA, 1'b0, 32'h0);
    chk("captured tdo", {24'h0, q[31:24]}, {24'h0, PAT[8*k+:8]});
    chk("setup skew", 32'(skew), 32'h0);
  endtask : t_shift

  task automatic t_idle();
    xfer(jvpe_pkg::A_PCT, 1'b1, 32'h19);
    xfer(jvpe_pkg::A_TIME, 1'b1, 32'd20);
    xfer(jvpe_pkg::A_CTRL, 1'b1, 32'h20);
    run(cmd(jvpe_pkg::OP_RUN, 1'b0, 1'b1, 24'h0));
    chk("idle time", 32'(cyc >= 1250), 32'h1);
    chk("idle exact", 32'(cyc <= 1300), 32'h1);
    chk("idle no clock", 32'(tk), 32'h0);
    xfer(jvpe_pkg::A_CTRL, 1'b1, 32'h28);
    run(cmd(jvpe_pkg::OP_RUN, 1'b0, 1'b1, 24'h0));
    chk("slow clocks", 32'(tk >= 1 && tk <= 4 && cyc >= 1250), 32'h1);
    xfer(jvpe_pkg::A_CTRL, 1'b1, 32'h30);
    run(cmd(jvpe_pkg::OP_RUN, 1'b0, 1'b1, 24'h0));
    chk("default clocks", 32'(tk >= 120), 32'h1);
    xfer(jvpe_pkg::A_CTRL, 1'b1, 32'h10);
    run(cmd(jvpe_pkg::OP_RUN, 1'b1, 1'b0, 24'd37));
    chk("count clocks", 32'(tk), 32'd37);
    xfer(jvpe_pkg::A_CTRL, 1'b1, 32'h30);
    run(cmd(jvpe_pkg::OP_RUN, 1'b1, 1'b0, 24'd20));
    chk("count as time", 32'(cyc >= 1250), 32'h1);
    xfer(jvpe_pkg::A_CTRL, 1'b1, 32'h20);
    run(cmd(jvpe_pkg::OP_RUN, 1'b1, 1'b1, 24'd3));
    chk("count and time", 32'(cyc >= 1250 && tk >= 3), 32'h1);
  endtask : t_idle

  task automatic t_aux();
    int r0;
    xfer(jvpe_pkg::A_CTRL, 1'b1, 32'h9c0);
    pins(1'b1, 1'b1);
    xfer(jvpe_pkg::A_CTRL, 1'b1, 32'h600);
    pins(1'b1, 1'b0);
    xfer(jvpe_pkg::A_CTRL, 1'b1, 32'h0c0);
    run(cmd(jvpe_pkg::OP_TRST, 1'b1, 1'b0, 24'h0));
    pins(1'b1, 1'b1);
    run(cmd(jvpe_pkg::OP_TRST, 1'b0, 1'b0, 24'h0));
    pins(1'b1, 1'b0);
    xfer(jvpe_pkg::A_CTRL, 1'b1, 32'h170);
    r0 = aux_rises;
    run(cmd(jvpe_pkg::OP_RUN, 1'b0, 1'b1, 24'h0));
    chk("aux clock", 32'(aux_rises - r0), 32'(tk));
    chk("aux clocked", 32'(tk > 0), 32'h1);
  endtask : t_aux

  task automatic t_prof();
    logic [31:0] pp[3] = '{32'h1, 32'h2, 32'h0};
    logic [12:0] pc[3] = '{jvpe_pkg::CTRL_CPLD, jvpe_pkg::CTRL_MCU, jvpe_pkg::CTRL_FPGA};
    logic [15:0] pd[3] = '{jvpe_pkg::DIV_CPLD, jvpe_pkg::DIV_MCU, jvpe_pkg::DIV_FPGA};
    logic [7:0]  pq[3] = '{jvpe_pkg::PCT_CPLD, jvpe_pkg::PCT_MCU, jvpe_pkg::PCT_FPGA};
    for (int i = 0; i < 3; i++) begin
      xfer(jvpe_pkg::A_PROF, 1'b1, pp[i]);
      xfer(jvpe_pkg::A_CTRL, 1'b0, 32'h0);
      chk("profile ctrl", q, {19'h0, pc[i]});
      xfer(jvpe_pkg::A_DDIV, 1'b0, 32'h0);
      chk("profile ddiv", q, {16'h0, pd[i]});
      xfer(jvpe_pkg::A_PCT, 1'b0, 32'h0);
      chk("profile pct", q, {24'h0, pq[i]});
      div_is(pd[i]);
    end
  endtask : t_prof
  // ==========================================================
  // Main sequence
  initial begin
    rst_i = 1'b1;
    wb = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_freq();
    t_shift(32'h30, 8'ha5, 8'h3c, 0);
    t_shift(32'h34, 8'h69, 8'hc3, 1);
    t_idle();
    t_aux();
    t_prof();
    summarize();
  end
endmodule : jvpe_engine_tb

// ---- jvpe_pkg.sv ----
// Constants, carriers and state layout of the boundary-scan vector engine.
// Assumes a 50 MHz system clock and a classic Wishbone register master.
package jvpe_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_HZ     = 50_000_000;
  localparam int TCK_MAX_HZ = 15_000_000;
  localparam int SLOW_HZ    = 100_000;
  localparam int SCALE_HZ   = 1_000_000;
  localparam int CPLD_HZ    = 5_000_000;
  localparam int MCU_HZ     = 1_000_000;
  localparam int MIN_HALF   = (CLK_HZ + 2 * TCK_MAX_HZ - 1) / (2 * TCK_MAX_HZ);
  localparam int SLOW_HALF  = CLK_HZ / (2 * SLOW_HZ);
  localparam int US_CYC     = CLK_HZ / SCALE_HZ;
  localparam int PCT_BASE   = 100;
  localparam int SHIFT_MAX  = 32;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DDIV = 8'h04;
  localparam logic [7:0] A_PCT  = 8'h08;
  localparam logic [7:0] A_CMD  = 8'h0c;
  localparam logic [7:0] A_DATA = 8'h10;
  localparam logic [7:0] A_TMS  = 8'h14;
  localparam logic [7:0] A_TIME = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1c;
  localparam logic [7:0] A_PROF = 8'h20;
  // ==========================================================
  // Command and mode codes
  localparam logic [1:0] OP_SHIFT = 2'h0;
  localparam logic [1:0] OP_RUN   = 2'h1;
  localparam logic [1:0] OP_FREQ  = 2'h2;
  localparam logic [1:0] OP_TRST  = 2'h3;
  localparam logic [1:0] IDLE_NONE = 2'h0;
  localparam logic [1:0] IDLE_SLOW = 2'h1;
  localparam logic [1:0] IDLE_DEF  = 2'h2;
  localparam logic [1:0] AUX_TRI  = 2'h0;
  localparam logic [1:0] AUX_TRST = 2'h1;
  localparam logic [1:0] AUX_SCK  = 2'h2;
  localparam logic [1:0] PROF_CPLD = 2'h1;
  localparam logic [1:0] PROF_MCU  = 2'h2;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SHIFT = 2'b01, ST_RUN = 2'b10} jvpe_fsm_t;
  typedef struct packed {
    logic       aft_lvl;
    logic       run_lvl;
    logic [1:0] aux_aft;
    logic [1:0] aux_run;
    logic       running;
    logic       cnt_time;
    logic [1:0] idle;
    logic       fast;
    logic       ext_fmt;
    logic       ign_freq;
  } jvpe_ctrl_t;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } jvpe_wb_t;
  typedef struct packed {
    jvpe_fsm_t   fsm;
    jvpe_ctrl_t  ctrl;
    logic [15:0] defdiv, curdiv, rdiv, half, acc;
    logic [7:0]  pct;
    logic [31:0] data, tmsr, cap, rdat;
    logic [23:0] timeus, cnt, us_left;
    logic        cnt_v, time_v, clk_on, trst_lvl;
    logic        tck, tdi, tms, aux, aux_oe, ack, tdo_s1, tdo_s2;
  } jvpe_state_t;
  // ==========================================================
  // Profiles: FPGA is the reset profile
  localparam jvpe_ctrl_t  CTRL_FPGA = 13'h0035;
  localparam jvpe_ctrl_t  CTRL_CPLD = 13'h002d;
  localparam jvpe_ctrl_t  CTRL_MCU  = 13'h0031;
  localparam logic [15:0] DIV_FPGA  = 16'(MIN_HALF);
  localparam logic [15:0] DIV_CPLD  = 16'(CLK_HZ / (2 * CPLD_HZ));
  localparam logic [15:0] DIV_MCU   = 16'(CLK_HZ / (2 * MCU_HZ));
  localparam logic [7:0]  PCT_FPGA  = 8'h00;
  localparam logic [7:0]  PCT_CPLD  = 8'h64;
  localparam logic [7:0]  PCT_MCU   = 8'h19;
endpackage : jvpe_pkg

// ---- jvpe_tap_model.sv ----
// Behavioural target test access port for the vector engine bench.
// Assumes tck_i stays low between operations and starts low after reset.
`timescale 1ns/1ps
module jvpe_tap_model #(
  parameter logic [31:0] PATTERN = 32'h0
) (
  input  wire logic        tck_i,
  input  wire logic        tdi_i,
  input  wire logic        tms_i,
  output logic             tdo_o,
  output logic [31:0]      tdi_cap_o,
  output logic [31:0]      tms_cap_o
);
  // ==========================================================
  // Capture and answer
  logic [31:0] pat = PATTERN;
  logic        armed = 1'b0;
  always @(posedge tck_i) begin
    armed <= 1'b1;
    tdi_cap_o <= {tdi_i, tdi_cap_o[31:1]};
    tms_cap_o <= {tms_i, tms_cap_o[31:1]};
  end
  // Output moves on the falling edge only, ignoring the first edge out of unknown
  always @(negedge tck_i) begin
    if (armed) pat <= {pat[0], pat[31:1]};
  end
  assign tdo_o = pat[0];
endmodule : jvpe_tap_model
